/* File: design/net_station_policy.sv */
// per-station pause, change broadcast, run follow and remote io policy
`timescale 1ns/1ps
module net_station_policy #(
    parameter int pause_w = station_policy_pkg::pause_w
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // configuration
    input wire logic [3:0] station_number,
    input wire logic [3:0] pause_scale_setting,
    input wire logic scale_write,
    input wire logic broadcast_setting,
    input wire logic broadcast_write,
    input wire logic follow_setting,
    input wire logic follow_write,
    // network timing measured by the link
    input wire logic [pause_w-1:0] base_pause_time,
    // program and operator state
    input wire logic program_present,
    input wire logic operator_entry,
    input wire logic manual_run,
    input wire logic manual_stop,
    // master mode seen on the net
    input wire logic master_run_change,
    input wire logic master_run_level,
    input wire logic master_fault_stop,
    // local io change
    input wire logic io_change,
    // remote write request
    input wire logic remote_write_req,
    input wire logic [3:0] remote_writer,
    // outputs
    output logic [3:0] pause_scale_q,
    output logic [pause_w+3:0] effective_pause_q,
    output logic broadcast_en_q,
    output logic follow_en_q,
    output logic change_telegram_q,
    output logic running_q,
    output logic remote_io_q,
    output logic remote_write_grant_q
);
    // refuse a pause width that the product register cannot hold
    if (pause_w < 1 || pause_w > 28)
    begin : g_bad_pause_w
        $error("pause_w out of range");
    end

    // next values and decoded station facts
    logic [3:0] pause_scale_d;
    logic [pause_w+3:0] effective_pause_d;
    logic broadcast_en_d, follow_en_d, change_telegram_d, running_d;
    logic remote_io_d, remote_write_grant_d;
    logic valid_number, is_master, is_follower;
    logic follow_open, writer_is_master;

    // station classification and follow gate
    always_comb
    begin
        valid_number = station_number != station_policy_pkg::station_unassigned &&
                       station_number <= station_policy_pkg::station_last;
        is_master = station_number == station_policy_pkg::station_master;
        is_follower = valid_number && !is_master;
        // programless stations have no menu, so entry never shuts their gate
        follow_open = is_follower && follow_en_q && (remote_io_q || !operator_entry);
        writer_is_master = remote_writer == station_policy_pkg::station_master;
    end

    // next configuration: load on strobe, follow locked off at station one
    always_comb
    begin
        pause_scale_d = pause_scale_q;
        if (scale_write)
            pause_scale_d = pause_scale_setting;
        broadcast_en_d = broadcast_en_q;
        if (broadcast_write)
            broadcast_en_d = broadcast_setting;
        follow_en_d = follow_en_q;
        if (follow_write)
            follow_en_d = follow_setting;
        if (is_master)
            follow_en_d = 1'b0;
    end

    // configuration registers
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pause_scale_q <= station_policy_pkg::scale_reset;
            broadcast_en_q <= station_policy_pkg::broadcast_reset;
            follow_en_q <= station_policy_pkg::follow_reset;
        end
        else
        begin
            pause_scale_q <= pause_scale_d;
            broadcast_en_q <= broadcast_en_d;
            follow_en_q <= follow_en_d;
        end
    end

    // effective pause: exact integer product, one cycle behind the multiplier
    always_comb
    begin
        // base pause is measured by the link itself
        effective_pause_d = (pause_w + 4)'(base_pause_time) *
                            (pause_w + 4)'({1'b0, pause_scale_q} + 5'h01);
    end

    // pause register
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            effective_pause_q <= '0;
        else
            effective_pause_q <= effective_pause_d;
    end

    // extra telegram per io change; programless stations other than station one ignore the enable
    always_comb
    begin
        change_telegram_d = io_change && (broadcast_en_q || remote_io_q);
    end

    // telegram strobe register
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            change_telegram_q <= 1'b0;
        else
            change_telegram_q <= change_telegram_d;
    end

    // run state: manual strobes first, master mode wins while the gate is open
    always_comb
    begin
        running_d = running_q;
        if (manual_stop)
            running_d = 1'b0;
        else if (manual_run)
            running_d = 1'b1;
        // a change seen while the gate is shut is dropped, never stored
        if (follow_open)
        begin
            if (master_fault_stop)
                running_d = 1'b0;
            else if (master_run_change)
                running_d = master_run_level;
        end
    end

    // run register
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            running_q <= 1'b0;
        else
            running_q <= running_d;
    end

    // remote io tracks program presence, never at station one; only station one may write outputs
    always_comb
    begin
        remote_io_d = !program_present && !is_master;
        remote_write_grant_d = remote_write_req && remote_io_q &&
                               writer_is_master;
    end

    // remote io and write grant registers
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            remote_io_q <= 1'b1;
            remote_write_grant_q <= 1'b0;
        end
        else
        begin
            remote_io_q <= remote_io_d;
            remote_write_grant_q <= remote_write_grant_d;
        end
    end

    // checks
    a_pause_product: assert property (@(posedge mclk) disable iff (!reset_n)
        $past(reset_n) |->
        effective_pause_q == $past(base_pause_time) * ($past(pause_scale_q) + 1))
        else $error("effective pause wrong");
    a_master_nofollow: assert property (@(posedge mclk) disable iff (!reset_n)
        $past(reset_n) && $past(is_master) |-> !follow_en_q)
        else $error("station one follows");
    a_change_sent: assert property (@(posedge mclk) disable iff (!reset_n)
        io_change && remote_io_q |=> change_telegram_q)
        else $error("programless change not sent");
    a_broadcast_gate: assert property (@(posedge mclk) disable iff (!reset_n)
        change_telegram_q |-> $past(io_change) && ($past(broadcast_en_q) || $past(remote_io_q)))
        else $error("spurious telegram");
    a_follow_run: assert property (@(posedge mclk) disable iff (!reset_n)
        is_follower && follow_en_q && !operator_entry && master_run_change &&
        !master_fault_stop |=> running_q == $past(master_run_level))
        else $error("follower missed mode");
    a_entry_blocks: assert property (@(posedge mclk) disable iff (!reset_n)
        operator_entry && !remote_io_q && !manual_run && !manual_stop |=> $stable(running_q))
        else $error("mode changed during entry");
    a_fault_stop: assert property (@(posedge mclk) disable iff (!reset_n)
        is_follower && follow_en_q && !operator_entry && master_fault_stop |=> !running_q)
        else $error("fault stop not followed");
    a_write_grant: assert property (@(posedge mclk) disable iff (!reset_n)
        remote_write_grant_q |-> $past(remote_writer) == station_policy_pkg::station_master &&
        $past(remote_io_q))
        else $error("illegal remote write");
    a_program_ends: assert property (@(posedge mclk) disable iff (!reset_n)
        program_present |=> !remote_io_q)
        else $error("remote io still on");
    a_scale_load: assert property (@(posedge mclk) disable iff (!reset_n)
        scale_write |=> pause_scale_q == $past(pause_scale_setting))
        else $error("multiplier not loaded");
    a_number_range: assert property (@(posedge mclk) disable iff (!reset_n)
        !valid_number && !manual_run && !manual_stop |=> $stable(running_q))
        else $error("unnumbered station changed mode");
    a_missed_dropped: assert property (@(posedge mclk) disable iff (!reset_n)
        !follow_open && !manual_run && !manual_stop |=> $stable(running_q))
        else $error("missed mode change applied");
    a_master_local: assert property (@(posedge mclk) disable iff (!reset_n)
        is_master |=> !remote_io_q)
        else $error("station one in remote io");
    // scenarios worth seeing
    c_follow: cover property (@(posedge mclk) disable iff (!reset_n) $rose(running_q));
    c_telegram: cover property (@(posedge mclk) disable iff (!reset_n) change_telegram_q);
    c_grant: cover property (@(posedge mclk) disable iff (!reset_n) remote_write_grant_q);
    c_fault: cover property (@(posedge mclk) disable iff (!reset_n)
        master_fault_stop ##1 $fell(running_q));
    c_manual_run: cover property (@(posedge mclk) disable iff (!reset_n)
        manual_run ##1 running_q);
endmodule

/* File: design/station_policy_pkg.sv */
// constants shared by the station policy block
// Function
// - pause multiplier resets to zero
// - station measures its own minimum pause
// - pause equals base times one plus multiplier
// - multiplier accepts zero through fifteen
// - change broadcast on after reset
// - each io change sent as own telegram
// - programless station always broadcasts changes; the code sends a programless station one's changes only while broadcast is on
// - follow master run on after reset
// - stations two to eight follow station one
// - station one cannot enable follow option
// - follow only when no operator entry pending; programless stations also follow during entry
// - missed mode change never applied later
// - station one fault stop stops followers
// - programless station runs in remote io; the code keeps station one out of remote io even without a program
// - program load ends remote io mode
// - only station one writes programless outputs
// - station number one to eight, zero unassigned
package station_policy_pkg;
    localparam int scale_w = 4;
    localparam logic [3:0] scale_reset = 4'h0;
    localparam int station_w = 4;
    localparam logic [3:0] station_unassigned = 4'h0;
    localparam logic [3:0] station_master = 4'h1;
    localparam logic [3:0] station_last = 4'h8;
    localparam int pause_w = 16;
    localparam logic broadcast_reset = 1'b1;
    localparam logic follow_reset = 1'b1;
    typedef enum logic [1:0] {
        run_stopped = 2'b00,
        run_running = 2'b01
    } run_state_t;
endpackage

/* File: verification/master_station_model.sv */
// far-side station model: mode changes and remote writes
`timescale 1ns/1ps
module master_station_model (
    // clock
    input wire logic mclk,
    // toward the station
    output logic master_run_change,
    output logic master_run_level,
    output logic master_fault_stop,
    output logic remote_write_req,
    output logic [3:0] remote_writer
);
    // quiet after power-up; the writer defaults to station one
    initial {master_run_change, master_run_level, master_fault_stop, remote_write_req} = 4'h0;
    initial remote_writer = 4'h1;
    // one-cycle mode or fault pulse, launched at the falling edge
    task automatic mode(input logic lvl, input logic flt);
        master_run_level = lvl;
        {master_fault_stop, master_run_change} = flt ? 2'b10 : 2'b01;
        @(negedge mclk);
        {master_fault_stop, master_run_change} = 2'b00;
        master_run_level = ~lvl;
    endtask
    // one-cycle output write request from station who
    task automatic wr(input logic [3:0] who);
        remote_writer = who;
        remote_write_req = 1'b1;
        @(negedge mclk);
        remote_write_req = 1'b0;
        remote_writer = ~who;
    endtask
endmodule

/* File: verification/tb_net_station_policy.sv */
// self-checking bench for the station policy block
`timescale 1ns/1ps
module tb_net_station_policy;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] station_number = 4'h2, pause_scale_setting = 4'h0, pause_scale_q, remote_writer;
    logic scale_write = 1'b0, broadcast_setting = 1'b1, broadcast_write = 1'b0;
    logic follow_setting = 1'b1, follow_write = 1'b0, program_present = 1'b0;
    logic operator_entry = 1'b0, io_change = 1'b0, manual_run = 1'b0, manual_stop = 1'b0;
    logic [15:0] base_pause_time = 16'h0123;
    logic [19:0] effective_pause_q;
    logic broadcast_en_q, follow_en_q, change_telegram_q, running_q, remote_io_q;
    logic remote_write_grant_q, master_run_change, master_run_level, master_fault_stop;
    logic remote_write_req;
    int failures = 0, samples_checked = 0, cycles = 0;
    always #2.5 mclk = ~mclk;
    net_station_policy u_dut (.mclk(mclk), .reset_n(reset_n), .station_number(station_number),
        .pause_scale_setting(pause_scale_setting), .scale_write(scale_write),
        .broadcast_setting(broadcast_setting), .broadcast_write(broadcast_write),
        .follow_setting(follow_setting), .follow_write(follow_write),
        .base_pause_time(base_pause_time), .program_present(program_present),
        .operator_entry(operator_entry), .manual_run(manual_run), .manual_stop(manual_stop),
        .master_run_change(master_run_change), .master_run_level(master_run_level),
        .master_fault_stop(master_fault_stop), .io_change(io_change),
        .remote_write_req(remote_write_req), .remote_writer(remote_writer),
        .pause_scale_q(pause_scale_q), .effective_pause_q(effective_pause_q),
        .broadcast_en_q(broadcast_en_q), .follow_en_q(follow_en_q),
        .change_telegram_q(change_telegram_q), .running_q(running_q),
        .remote_io_q(remote_io_q), .remote_write_grant_q(remote_write_grant_q));
    master_station_model u_peer (.mclk(mclk), .master_run_change(master_run_change),
        .master_run_level(master_run_level), .master_fault_stop(master_fault_stop),
        .remote_write_req(remote_write_req), .remote_writer(remote_writer));
    // compare and count
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one-cycle strobe from a falling edge
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge mclk);
        s = 1'b0;
    endtask
    // counts, verdict, end of run
    task automatic report_and_stop;
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 600)
        begin
            failures++;
            report_and_stop();
        end
    end
    // main sequence
    initial
    begin
        repeat (20) @(negedge mclk);
        reset_n = 1'b1;
        @(negedge mclk);
        check(20'(pause_scale_q), 20'h00000);
        check(20'({broadcast_en_q, follow_en_q}), 20'h00003);
        check(20'(remote_io_q), 20'h00001);
        check(effective_pause_q, 20'h00123);
        for (int n = 15; n >= 0; n--)
        begin
            pause_scale_setting = 4'(n);
            pulse(scale_write);
            @(negedge mclk);
            check(effective_pause_q, 20'(20'h00123 * (n + 1)));
        end
        broadcast_setting = 1'b0; // as a fast counting station would
        pulse(broadcast_write);
        pulse(io_change);
        check(20'(change_telegram_q), 20'h00001);
        u_peer.wr(4'h1);
        check(20'(remote_write_grant_q), 20'h00001);
        @(negedge mclk);
        u_peer.wr(4'h3);
        check(20'(remote_write_grant_q), 20'h00000);
        program_present = 1'b1;
        @(negedge mclk);
        check(20'(remote_io_q), 20'h00000);
        pulse(io_change);
        check(20'({remote_io_q, change_telegram_q}), 20'h00000);
        u_peer.wr(4'h1);
        check(20'(remote_write_grant_q), 20'h00000);
        broadcast_setting = 1'b1;
        pulse(broadcast_write);
        pulse(io_change);
        check(20'(change_telegram_q), 20'h00001);
        u_peer.mode(1'b1, 1'b0);
        check(20'(running_q), 20'h00001);
        operator_entry = 1'b1;
        @(negedge mclk);
        u_peer.mode(1'b0, 1'b0);
        operator_entry = 1'b0;
        check(20'(running_q), 20'h00001);
        @(negedge mclk);
        check(20'(running_q), 20'h00001);
        u_peer.mode(1'b1, 1'b1);
        check(20'(running_q), 20'h00000);
        // a run order missed during entry stays missed until a manual run
        operator_entry = 1'b1;
        @(negedge mclk);
        u_peer.mode(1'b1, 1'b0);
        operator_entry = 1'b0;
        @(negedge mclk);
        check(20'(running_q), 20'h00000);
        pulse(manual_run);
        check(20'(running_q), 20'h00001);
        pulse(manual_stop);
        check(20'(running_q), 20'h00000);
        pulse(manual_run);
        check(20'(running_q), 20'h00001);
        u_peer.mode(1'b0, 1'b0);
        check(20'(running_q), 20'h00000);
        // unassigned and out-of-range numbers never follow
        station_number = 4'h0;
        @(negedge mclk);
        u_peer.mode(1'b1, 1'b0);
        check(20'(running_q), 20'h00000);
        station_number = 4'h9;
        @(negedge mclk);
        u_peer.mode(1'b1, 1'b0);
        check(20'(running_q), 20'h00000);
        station_number = 4'h1;
        pulse(follow_write);
        @(negedge mclk);
        check(20'(follow_en_q), 20'h00000);
        report_and_stop();
    end
endmodule
